// file: tec_consts.vh
// register map, field positions, reset values and timing for the event timer
`ifndef TEC_CONSTS_VH
`define TEC_CONSTS_VH
`define TEC_ADDR_W          4
`define TEC_OFS_CTRL0       4'h0
`define TEC_OFS_CTRL1       4'h1
`define TEC_OFS_PRELOAD0    4'h2
`define TEC_OFS_PRELOAD1    4'h3
`define TEC_OFS_COUNT0      4'h4
`define TEC_OFS_COUNT1      4'h5
`define TEC_OFS_INTEN       4'h6
`define TEC_OFS_STATUS      4'h7
`define TEC_MODE_HI         7
`define TEC_MODE_LO         6
`define TEC_CLKSEL          5
`define TEC_RUN             4
`define TEC_EDGE            3
`define TEC_PSC_HI          2
`define TEC_CTRL_RST        8'h08
`define TEC_MODE_NONE       2'b00
`define TEC_MODE_EVENT      2'b01
`define TEC_MODE_TIMER      2'b10
`define TEC_MODE_PWC        2'b11
`define TEC_FULL            8'hff
`define TEC_SYSDIV          4
`endif

// file: tec_timer.v
// two 8-bit timer/event counters with preload, prescaler and pulse capture
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "tec_consts.vh"
module tec_timer #(
    parameter CNT_W = 8
) (
    // clock and reset
    input  wire              i_mclk,
    input  wire              i_rst,
    // register port
    input  wire [3:0]        i_addr,
    input  wire [7:0]        i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    output reg  [7:0]        o_rdata,
    // external timer pins and low-speed crystal clock level
    input  wire [1:0]        i_ext_timer_pin,
    input  wire              i_low_speed_crystal_clock,
    // interrupt requests and wake-up to the interrupt controller
    output reg  [1:0]        o_irq,
    output reg               o_wake,
    // raw overflow strobes
    output reg  [1:0]        o_ovf
);

    // register file
    reg  [7:0]       ctrl_r [0:1];
    reg  [CNT_W-1:0] pre_r  [0:1];
    reg  [CNT_W-1:0] cnt_r  [0:1];
    reg  [1:0]       inten_r;
    reg  [1:0]       req_r;

    // pin synchroniser and internal clock edge detection
    reg  [2:0]       pin_s0_r, pin_s1_r, pin_s2_r;
    reg  [1:0]       pin_lvl_r;
    reg  [1:0]       sysdiv_r;
    reg  [7:0]       psc_r;
    reg              psc_tick_prev_r;
    reg              div4_prev_r;
    reg              xtal_prev_r;
    wire [2:0]       pin_raw;
    wire [1:0]       pin_rise, pin_fall;
    wire             xtal_lvl, xtal_fall;
    wire             div4_fall;
    wire             psc_sel, psc_fall;

    // per-counter strobes, one bit per counter
    wire [1:0]       tick;
    wire [1:0]       ovf;
    wire [1:0]       pwc_stop;

    assign pin_raw = {i_low_speed_crystal_clock, i_ext_timer_pin};

    // three-stage sync; a change counts once stages two and three agree
    // levels reset to zero: an idle-high pin gives one stray edge,
    // harmless because every counter is still stopped then
    // stage one feeds only stage two
    always @(posedge i_mclk) begin
        if (i_rst) begin
            pin_s0_r  <= 3'h0;
            pin_s1_r  <= 3'h0;
            pin_s2_r  <= 3'h0;
            pin_lvl_r <= 2'h0;
            xtal_prev_r <= 1'b0;
        end else begin
            pin_s0_r <= pin_raw;
            pin_s1_r <= pin_s0_r;
            pin_s2_r <= pin_s1_r;
            if (pin_s1_r[2] == pin_s2_r[2])
                xtal_prev_r <= pin_s2_r[2];
            if (pin_s1_r[0] == pin_s2_r[0])
                pin_lvl_r[0] <= pin_s2_r[0];
            if (pin_s1_r[1] == pin_s2_r[1])
                pin_lvl_r[1] <= pin_s2_r[1];
        end
    end

    assign pin_rise = (pin_s1_r[1:0] == pin_s2_r[1:0]) &
                      pin_s2_r[1:0] & ~pin_lvl_r;
    assign pin_fall = (pin_s1_r[1:0] == pin_s2_r[1:0]) &
                      ~pin_s2_r[1:0] & pin_lvl_r;

    assign xtal_lvl  = pin_s2_r[2];
    // crystal falls once stages agree, as for the pins
    assign xtal_fall = (pin_s1_r[2] == pin_s2_r[2]) & xtal_prev_r & ~xtal_lvl;

    // system clock divided by four for counter 1
    // free-running, so the first tick after run comes within four clocks
    always @(posedge i_mclk) begin
        if (i_rst) begin
            sysdiv_r    <= 2'h0;
            div4_prev_r <= 1'b0;
        end else begin
            sysdiv_r    <= sysdiv_r + 2'h1;
            div4_prev_r <= sysdiv_r[1];
        end
    end
    assign div4_fall = div4_prev_r & ~sysdiv_r[1];

    // counter 0 prescaler: ratio 2^(sel+1), count on falling output edge
    // free-running: the phase at run start is not aligned to the write
    always @(posedge i_mclk) begin
        if (i_rst) begin
            psc_r           <= 8'h00;
            psc_tick_prev_r <= 1'b0;
        end else begin
            psc_r           <= psc_r + 8'h01;
            psc_tick_prev_r <= psc_sel;
        end
    end
    assign psc_sel  = psc_r[ctrl_r[0][`TEC_PSC_HI:0]];
    assign psc_fall = psc_tick_prev_r & ~psc_sel;

    // one slice per counter; counter 0 has the prescaler,
    // counter 1 the clock select
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_cnt
            wire [1:0] mode = ctrl_r[g][`TEC_MODE_HI:`TEC_MODE_LO];
            wire       run  = ctrl_r[g][`TEC_RUN];
            wire       edg  = ctrl_r[g][`TEC_EDGE];
            wire       iclk;
            wire       start_e, stop_e;
            if (g == 0) begin : g_c0
                assign iclk = psc_fall;
            end else begin : g_c1
                assign iclk = ctrl_r[1][`TEC_CLKSEL] ? xtal_fall
                                                     : div4_fall;
            end
            assign start_e = edg ? pin_rise[g] : pin_fall[g];
            assign stop_e  = edg ? pin_fall[g] : pin_rise[g];

            // capture is armed between its start and stop edges
            reg        act_r;
            reg        tick_c;
            reg        stop_c;

            always @* begin
                tick_c = 1'b0;
                stop_c = 1'b0;
                if (run) begin
                    case (mode)
                    `TEC_MODE_EVENT:
                        // pin edges count directly, even in sleep
                        tick_c = edg ? pin_fall[g]
                                     : pin_rise[g];
                    `TEC_MODE_TIMER:
                        tick_c = iclk;
                    `TEC_MODE_PWC: begin
                        tick_c = act_r & iclk & ~stop_e;
                        stop_c = act_r & stop_e;
                    end
                    default:
                        tick_c = 1'b0;
                    endcase
                end
            end
            assign tick[g]     = tick_c;
            assign pwc_stop[g] = stop_c;
            assign ovf[g]      = tick_c & (cnt_r[g] == `TEC_FULL);

            always @(posedge i_mclk) begin
                if (i_rst) begin
                    act_r <= 1'b0;
                end else if (!run || mode != `TEC_MODE_PWC) begin
                    act_r <= 1'b0;
                end else if (stop_c) begin
                    act_r <= 1'b0;
                end else if (start_e) begin
                    act_r <= 1'b1;
                end
            end
        end
    endgenerate

    // write decodes
    wire       wr_inten = i_wr && (i_addr == `TEC_OFS_INTEN);
    wire       wr_ctrl0 = i_wr && (i_addr == `TEC_OFS_CTRL0);
    wire       wr_ctrl1 = i_wr && (i_addr == `TEC_OFS_CTRL1);
    wire       wr_pre0  = i_wr && (i_addr == `TEC_OFS_PRELOAD0);
    wire       wr_pre1  = i_wr && (i_addr == `TEC_OFS_PRELOAD1);
    wire       wr_sts   = i_wr && (i_addr == `TEC_OFS_STATUS);

    // control, preload and enable registers
    always @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_r[0] <= `TEC_CTRL_RST;
            ctrl_r[1] <= `TEC_CTRL_RST;
            pre_r[0]  <= {CNT_W{1'b0}};
            pre_r[1]  <= {CNT_W{1'b0}};
            inten_r   <= 2'h0;
        end else begin
            if (wr_ctrl0)
                ctrl_r[0] <= i_wdata;
            else if (pwc_stop[0])
                ctrl_r[0][`TEC_RUN] <= 1'b0;
            if (wr_ctrl1)
                ctrl_r[1] <= {i_wdata[7:3], 3'h0};
            else if (pwc_stop[1])
                ctrl_r[1][`TEC_RUN] <= 1'b0;
            if (wr_inten)
                inten_r <= i_wdata[1:0];
            if (wr_pre0)
                pre_r[0] <= i_wdata;
            if (wr_pre1)
                pre_r[1] <= i_wdata;
        end
    end

    // counters; a stopped preload write goes straight in
    always @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_r[0] <= {CNT_W{1'b0}};
            cnt_r[1] <= {CNT_W{1'b0}};
        end else begin
            // preload writes while running wait for the next reload
            if (wr_pre0 && !ctrl_r[0][`TEC_RUN])
                cnt_r[0] <= i_wdata;
            else if (ovf[0])
                cnt_r[0] <= pre_r[0];
            else if (tick[0])
                cnt_r[0] <= cnt_r[0] + 8'h01;
            // the overflowing tick reloads rather than wrapping to zero
            if (wr_pre1 && !ctrl_r[1][`TEC_RUN])
                cnt_r[1] <= i_wdata;
            else if (ovf[1])
                cnt_r[1] <= pre_r[1];
            else if (tick[1])
                cnt_r[1] <= cnt_r[1] + 8'h01;
        end
    end

    // sticky requests; a new overflow wins over a software clear
    always @(posedge i_mclk) begin
        if (i_rst) begin
            req_r <= 2'h0;
        end else begin
            req_r <= (req_r & ~({2{wr_sts}} & i_wdata[1:0])) | ovf;
        end
    end

    // outputs lag the pending bits and overflow strobes by one clock so each is a flip-flop
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_irq  <= 2'h0;
            o_wake <= 1'b0;
            o_ovf  <= 2'h0;
        end else begin
            o_irq  <= req_r & inten_r;
            o_wake <= |(req_r & inten_r);
            o_ovf  <= ovf;
        end
    end

    // read port: data valid the cycle after the strobe
    // unmapped addresses and idle cycles read as zero
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr == `TEC_OFS_CTRL0)
                o_rdata <= ctrl_r[0];
            else if (i_addr == `TEC_OFS_CTRL1)
                o_rdata <= {ctrl_r[1][7:3], 3'h0};
            else if (i_addr == `TEC_OFS_PRELOAD0)
                o_rdata <= pre_r[0];
            else if (i_addr == `TEC_OFS_PRELOAD1)
                o_rdata <= pre_r[1];
            else if (i_addr == `TEC_OFS_COUNT0)
                o_rdata <= cnt_r[0];
            else if (i_addr == `TEC_OFS_COUNT1)
                o_rdata <= cnt_r[1];
            else if (i_addr == `TEC_OFS_INTEN)
                o_rdata <= {6'h00, inten_r};
            else if (i_addr == `TEC_OFS_STATUS)
                o_rdata <= {6'h00, req_r};
            else
                o_rdata <= 8'h00;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// file: tec_properties.sv
// port-level assertion checker for the event timer
`include "tec_consts.vh"
module tec_props (
    input wire       i_mclk,
    input wire       i_rst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire [1:0] o_irq,
    input wire       o_wake,
    input wire [1:0] o_ovf
);
    reg [1:0] en_r;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // shadow of the enable register, seen from the write strobe only
    always @(posedge i_mclk)
        if (i_rst)
            en_r <= 2'h0;
        else if (i_wr && i_addr == `TEC_OFS_INTEN)
            en_r <= i_wdata[1:0];
    sequence s_ctrl1_rd;
        i_rd && i_addr == `TEC_OFS_CTRL1;
    endsequence
    sequence s_far_rd;
        i_rd && i_addr > 4'h7;
    endsequence
    ctrl1_low_zero_a: assert property (s_ctrl1_rd |=> o_rdata[2:0] == 3'h0)
        else $error("ctrl1 low bits not zero");
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (s_far_rd |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    ovf_single_a: assert property ((o_ovf & $past(o_ovf)) == 2'h0)
        else $error("overflow strobe longer than one cycle");
    irq0_follows_a: assert property (o_ovf[0] && en_r[0] |-> ##[0:1] o_irq[0])
        else $error("counter 0 overflow without request");
    irq1_follows_a: assert property (o_ovf[1] && en_r[1] |-> ##[0:1] o_irq[1])
        else $error("counter 1 overflow without request");
    irq_masked_a: assert property ((o_irq & ~$past(en_r)) == 2'h0)
        else $error("request while disabled");
    wake_on_irq_a: assert property ($rose(|o_irq) |-> ##[0:1] o_wake)
        else $error("no wake on request");
    wake_quiet_a: assert property ((o_irq == 2'h0)[*2] |-> !o_wake)
        else $error("wake without request");
endmodule
bind tec_timer tec_props u_tec_props (.i_mclk, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_irq, .o_wake, .o_ovf);

// file: tec_pin_model.sv
// far-side source of level changes on the two external timer pins
module tec_pin_src (
    input  wire        i_mclk,
    output logic [1:0] o_pin,
    output logic       o_xtal
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins idle high, as with a pull-up fitted
    initial o_pin = 2'h3;
    // slow crystal level, ten bench clocks per period
    initial o_xtal = 1'b0;
    always begin
        repeat (5) @(posedge i_mclk);
        o_xtal <= ~o_xtal;
    end
    // the gap stays above the synchroniser delay so each change counts once
    task automatic drive(input int idx, input logic lvl, input int gap);
        @(posedge i_mclk);
        o_pin[idx] <= lvl;
        repeat (gap) @(posedge i_mclk);
    endtask
endmodule

// file: testbench.sv
// self-checking bench for the two-channel event timer
`include "tec_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_mclk, i_rst, i_wr, i_rd, o_wake;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rd_v;
    logic [1:0] o_irq, o_ovf, pin;
    logic       xtal;
    int         errors, compares;
    tec_timer u_tec_timer (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_ext_timer_pin(pin),
        .i_low_speed_crystal_clock(xtal), .o_irq, .o_wake, .o_ovf);
    tec_pin_src u_tec_pin_src (.i_mclk, .o_pin(pin), .o_xtal(xtal));
    task automatic wait_ovf(input int idx, output int n);
        n = 0;
        while (o_ovf[idx] !== 1'b1 && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
    endtask
    task automatic chk(input logic [7:0] g, x, input string m);
        compares++;
        if (g !== x) begin
            errors++;
            $display("unexpected at %0t: %s got %h", $time, m, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] x,
                      input string m);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rd_v = o_rdata;
        if (m != "") chk(rd_v, x, m);
    endtask
    task automatic t_reset();
        rd(`TEC_OFS_CTRL0, `TEC_CTRL_RST, "ctrl0 reset");
        rd(`TEC_OFS_CTRL1, `TEC_CTRL_RST, "ctrl1 reset");
        rd(4'hf, 8'h00, "unmapped read");
        wr(`TEC_OFS_COUNT0, 8'h55);
        rd(`TEC_OFS_COUNT0, 8'h00, "count read-only");
    endtask
    task automatic t_event();
        for (int e = 0; e < 2; e++) begin
            wr(`TEC_OFS_CTRL0, 8'h00);
            wr(`TEC_OFS_INTEN, e ? 8'h00 : 8'h01);
            wr(`TEC_OFS_PRELOAD0, 8'hfe);
            wr(`TEC_OFS_CTRL0, {`TEC_MODE_EVENT, 2'b01, e[0], 3'h7});
            rd(`TEC_OFS_COUNT0, 8'hfe, "stopped preload");
            u_tec_pin_src.drive(0, 1'b0, 8);
            rd(`TEC_OFS_COUNT0, e ? 8'hff : 8'hfe, "fall");
            u_tec_pin_src.drive(0, 1'b1, 8);
            rd(`TEC_OFS_COUNT0, 8'hff, "rise");
            u_tec_pin_src.drive(0, 1'b0, 8);
            u_tec_pin_src.drive(0, 1'b1, 8);
            rd(`TEC_OFS_COUNT0, 8'hfe, "reload");
            rd(`TEC_OFS_STATUS, 8'h01, "pending");
            chk({6'h0, o_irq}, e ? 8'h00 : 8'h01, "irq");
            chk({7'h0, o_wake}, e ? 8'h00 : 8'h01, "wake");
            wr(`TEC_OFS_STATUS, 8'h01);
            rd(`TEC_OFS_STATUS, 8'h00, "pending clear");
        end
    endtask
    task automatic t_hold();
        wr(`TEC_OFS_CTRL0, 8'h48);
        wr(`TEC_OFS_PRELOAD0, 8'h10);
        u_tec_pin_src.drive(0, 1'b0, 8);
        rd(`TEC_OFS_COUNT0, 8'h10, "held when off");
        u_tec_pin_src.drive(0, 1'b1, 8);
        wr(`TEC_OFS_CTRL0, 8'h18);
        u_tec_pin_src.drive(0, 1'b0, 8);
        rd(`TEC_OFS_COUNT0, 8'h10, "no mode");
        u_tec_pin_src.drive(0, 1'b1, 8);
        wr(`TEC_OFS_CTRL0, 8'h58);
        wr(`TEC_OFS_PRELOAD0, 8'h20);
        u_tec_pin_src.drive(0, 1'b0, 8);
        rd(`TEC_OFS_COUNT0, 8'h11, "running preload");
    endtask
    task automatic t_capture();
        logic [7:0] c;
        wr(`TEC_OFS_CTRL0, 8'h00);
        wr(`TEC_OFS_PRELOAD0, 8'h00);
        wr(`TEC_OFS_CTRL0, {`TEC_MODE_PWC, 6'h18});
        rd(`TEC_OFS_COUNT0, 8'h00, "armed idle");
        u_tec_pin_src.drive(0, 1'b1, 40);
        u_tec_pin_src.drive(0, 1'b0, 8);
        rd(`TEC_OFS_CTRL0, 8'hc8, "run cleared");
        rd(`TEC_OFS_COUNT0, 8'h00, "");
        c = rd_v;
        chk({7'h0, c > 8'h10 && c < 8'h18}, 8'h01, "width");
        u_tec_pin_src.drive(0, 1'b1, 20);
        rd(`TEC_OFS_COUNT0, c, "ignored after stop");
    endtask
    task automatic t_timer1();
        int n;
        wr(`TEC_OFS_INTEN, 8'h02);
        wr(`TEC_OFS_PRELOAD1, 8'hf0);
        wr(`TEC_OFS_CTRL1, 8'h97);
        rd(`TEC_OFS_CTRL1, 8'h90, "ctrl1 bits");
        wait_ovf(1, n);
        chk({7'h0, n > 55 && n < 72}, 8'h01, "sys/4 period");
        rd(`TEC_OFS_STATUS, 8'h02, "pending1");
        chk({6'h0, o_irq}, 8'h02, "irq1");
        wr(`TEC_OFS_CTRL1, 8'h00);
        wr(`TEC_OFS_PRELOAD1, 8'hf0);
        wr(`TEC_OFS_CTRL1, 8'hb0);
        wait_ovf(1, n);
        chk({7'h0, n > 145 && n < 180}, 8'h01, "crystal period");
        wr(`TEC_OFS_CTRL1, 8'h00);
        wr(`TEC_OFS_CTRL0, 8'h00);
        wr(`TEC_OFS_PRELOAD0, 8'hf0);
        wr(`TEC_OFS_CTRL0, 8'h91);
        wait_ovf(0, n);
        chk({7'h0, n > 56 && n < 72}, 8'h01, "psc /4 period");
        rd(`TEC_OFS_STATUS, 8'h03, "pending both");
        wr(`TEC_OFS_CTRL0, 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    initial begin
        errors = 0;
        compares = 0;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_reset();
        t_event();
        t_hold();
        t_capture();
        t_timer1();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        errors++;
        tally_and_finish();
    end
endmodule
